// [verilog/sep_pkg.sv]
package sep_pkg;
    // ==========================================
    // Array geometry
    localparam int ADDR_W = 8;
    localparam int MEM_DEPTH = 256;
    localparam int PAGE_BYTES = 16;
    localparam int PROT_BIT = 7;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [7:0] PTR_STEP = 8'h01;
    // ==========================================
    // Control byte
    localparam logic [3:0] CTRL_CODE = 4'ha;
    // ==========================================
    // Bit counting
    localparam logic [3:0] BIT_LAST = 4'h8;
    localparam logic [3:0] TX_LAST = 4'h7;
    // ==========================================
    // Self-timed write cycle, in core clocks
    localparam int DEF_WRITE_CYC = 1000;
    localparam int CNT_W = 16;
    // ==========================================
    // Byte handling states
    typedef enum logic [3:0] {
        ST_IDLE, ST_CTRL, ST_WADDR, ST_WDATA, ST_ACK_CTRL,
        ST_ACK_ADDR, ST_ACK_DATA, ST_TX, ST_RACK, ST_IGNORE
    } sep_state_e;
endpackage : sep_pkg

// [verilog/sep_link_if.sv]
`timescale 1ns/1ns
interface sep_link_if;
    logic start_tgl;
    logic stop_tgl;
    logic rise_tgl;
    logic fall_tgl;
    logic sda_lvl;
    modport front (output start_tgl, output stop_tgl, output rise_tgl,
                   output fall_tgl, output sda_lvl);
    modport core (input start_tgl, input stop_tgl, input rise_tgl,
                  input fall_tgl, input sda_lvl);
endinterface : sep_link_if

// [verilog/sep_link_front.sv]
`timescale 1ns/1ns
module sep_link_front (
    // Link clock and core reset
    input wire logic link_clk,
    input wire logic rstn,
    // Bus pins
    input wire logic scl_i,
    input wire logic sda_i,
    // Bus events towards the core
    sep_link_if.front lnk
);
    import sep_pkg::*;

    // ==========================================
    // Reset and pin synchronisers
    logic [1:0] rst_sync_reg;
    logic [2:0] scl_sync_reg;
    logic [2:0] sda_sync_reg;
    logic scl_st_reg;
    logic sda_st_reg;
    logic scl_prev_reg;
    logic sda_prev_reg;
    wire link_rstn = rst_sync_reg[1];

    always_ff @(posedge link_clk) begin
        rst_sync_reg <= {rst_sync_reg[0], rstn};
    end

    always_ff @(posedge link_clk) begin
        if (!link_rstn) begin
            scl_sync_reg <= 3'h7;
            sda_sync_reg <= 3'h7;
            scl_st_reg <= 1'b1;
            sda_st_reg <= 1'b1;
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else begin
            scl_sync_reg <= {scl_sync_reg[1:0], scl_i};
            sda_sync_reg <= {sda_sync_reg[1:0], sda_i};
            if (scl_sync_reg[1] == scl_sync_reg[2]) begin
                scl_st_reg <= scl_sync_reg[2];
            end
            if (sda_sync_reg[1] == sda_sync_reg[2]) begin
                sda_st_reg <= sda_sync_reg[2];
            end
            scl_prev_reg <= scl_st_reg;
            sda_prev_reg <= sda_st_reg;
        end
    end

    // ==========================================
    // Bus conditions, each flips its own toggle
    wire scl_high = scl_st_reg & scl_prev_reg;
    wire start_det = scl_high & sda_prev_reg & ~sda_st_reg;
    wire stop_det = scl_high & ~sda_prev_reg & sda_st_reg;
    wire rise_det = ~scl_prev_reg & scl_st_reg;
    wire fall_det = scl_prev_reg & ~scl_st_reg;

    always_ff @(posedge link_clk) begin
        if (!link_rstn) begin
            lnk.start_tgl <= 1'b0;
            lnk.stop_tgl <= 1'b0;
            lnk.rise_tgl <= 1'b0;
            lnk.fall_tgl <= 1'b0;
        end else begin
            lnk.start_tgl <= lnk.start_tgl ^ start_det;
            lnk.stop_tgl <= lnk.stop_tgl ^ stop_det;
            lnk.rise_tgl <= lnk.rise_tgl ^ rise_det;
            lnk.fall_tgl <= lnk.fall_tgl ^ fall_det;
        end
    end

    // Data level is settled long before the clock rises
    assign lnk.sda_lvl = sda_st_reg;
endmodule : sep_link_front

// [verilog/sep_eeprom_top.sv]
`timescale 1ns/1ns
module sep_eeprom_top #(
    parameter int WRITE_CYC = sep_pkg::DEF_WRITE_CYC
) (
    // Core clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Link sampling clock
    input wire logic link_clk,
    // Two-wire bus
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // Straps
    input wire logic wp_i,
    input wire logic chip_select_bit_2,
    input wire logic chip_select_bit_1,
    input wire logic chip_select_bit_0,
    // Status
    output logic write_busy
);
    import sep_pkg::*;

    if (WRITE_CYC <= PAGE_BYTES || WRITE_CYC >= 65536) begin : g_bad_cyc
        $error("WRITE_CYC out of range");
    end

    // ==========================================
    // Link front end
    sep_link_if lnk ();

    sep_link_front u_front (
        .link_clk(link_clk),
        .rstn(rstn),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .lnk(lnk)
    );

    // ==========================================
    // Event and strap synchronisers
    logic [4:0] ev_s1_reg;
    logic [4:0] ev_s2_reg;
    logic [4:0] ev_s3_reg;
    logic sda_lvl;
    logic [3:0] pin_s1_reg;
    logic [3:0] pin_s2_reg;
    logic [3:0] pin_s3_reg;
    logic [3:0] pin_st_reg;
    wire [4:0] ev_raw = {lnk.sda_lvl, lnk.fall_tgl, lnk.rise_tgl, lnk.stop_tgl, lnk.start_tgl};
    wire [3:0] pin_raw = {wp_i, chip_select_bit_2, chip_select_bit_1, chip_select_bit_0};

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            ev_s1_reg <= 5'h10;
            ev_s2_reg <= 5'h10;
            ev_s3_reg <= 5'h10;
            sda_lvl <= 1'b1;
            pin_s1_reg <= 4'h0;
            pin_s2_reg <= 4'h0;
            pin_s3_reg <= 4'h0;
            pin_st_reg <= 4'h0;
        end else begin
            ev_s1_reg <= ev_raw;
            ev_s2_reg <= ev_s1_reg;
            ev_s3_reg <= ev_s2_reg;
            if (ev_s2_reg[4] == ev_s3_reg[4]) begin
                sda_lvl <= ev_s3_reg[4];
            end
            pin_s1_reg <= pin_raw;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
            pin_st_reg <= (pin_s2_reg & pin_s3_reg) | (pin_st_reg & (pin_s2_reg | pin_s3_reg));
        end
    end

    wire start_ev = ev_s2_reg[0] ^ ev_s3_reg[0];
    wire stop_ev = ev_s2_reg[1] ^ ev_s3_reg[1];
    wire bit_ev = ev_s2_reg[2] ^ ev_s3_reg[2];
    wire fall_ev = ev_s2_reg[3] ^ ev_s3_reg[3];
    wire wp_on = pin_st_reg[3];
    wire [2:0] cs_lvl = pin_st_reg[2:0];

    function automatic logic is_protected(input logic [ADDR_W-1:0] addr, input logic wp);
        is_protected = wp & addr[PROT_BIT];
    endfunction : is_protected

    // ==========================================
    // State, array and page buffer
    sep_state_e st_reg;
    sep_state_e st_next;
    logic drv_low_reg;
    logic drv_low_next;
    logic [3:0] bitcnt_reg;
    logic [7:0] sh_reg;
    logic [7:0] tx_reg;
    logic rw_reg;
    logic [ADDR_W-1:0] ptr_reg;
    logic [3:0] wr_base_reg;
    logic [PAGE_BYTES-1:0] buf_vld_reg;
    logic wr_pend_reg;
    logic busy_reg;
    logic [CNT_W-1:0] busy_cnt_reg;
    logic [7:0] mem [MEM_DEPTH];
    logic [7:0] page_buf [PAGE_BYTES];

    wire rx_state = st_reg inside {ST_CTRL, ST_WADDR, ST_WDATA};
    wire ack_state = st_reg inside {ST_ACK_CTRL, ST_ACK_ADDR, ST_ACK_DATA};
    wire byte_done = fall_ev && rx_state && bitcnt_reg == BIT_LAST;
    wire ctrl_match = sh_reg[7:4] == CTRL_CODE && sh_reg[3:1] == cs_lvl;
    wire ctrl_ack = byte_done && st_reg == ST_CTRL && ctrl_match && !busy_reg;
    wire load_tx = fall_ev && ((st_reg == ST_ACK_CTRL && rw_reg) || st_reg == ST_RACK);
    wire [7:0] rd_data = mem[ptr_reg];
    wire [ADDR_W-1:0] ptr_inc = ptr_reg + PTR_STEP;
    wire [ADDR_W-1:0] page_inc = {ptr_reg[7:4], 4'(ptr_reg[3:0] + 4'h1)};
    wire commit_on = busy_reg && busy_cnt_reg <= CNT_W'(PAGE_BYTES) && busy_cnt_reg != '0;
    wire [3:0] commit_idx = 4'(busy_cnt_reg - CNT_W'(1));
    wire [ADDR_W-1:0] commit_addr = {wr_base_reg, commit_idx};
    wire commit_we = commit_on && buf_vld_reg[commit_idx] && !is_protected(commit_addr, wp_on);

    // ==========================================
    // Next state and data line drive
    always_comb begin
        st_next = st_reg;
        drv_low_next = drv_low_reg;
        if (start_ev) begin
            st_next = ST_CTRL;
            drv_low_next = 1'b0;
        end else if (stop_ev) begin
            st_next = ST_IDLE;
            drv_low_next = 1'b0;
        end else begin
            unique case (st_reg)
                ST_IDLE, ST_IGNORE: begin
                    st_next = st_reg;
                end
                ST_CTRL: begin
                    if (byte_done) begin
                        st_next = ctrl_ack ? ST_ACK_CTRL : ST_IGNORE;
                        drv_low_next = ctrl_ack;
                    end
                end
                ST_WADDR: begin
                    if (byte_done) begin
                        st_next = ST_ACK_ADDR;
                        drv_low_next = 1'b1;
                    end
                end
                ST_WDATA: begin
                    if (byte_done) begin
                        st_next = ST_ACK_DATA;
                        drv_low_next = 1'b1;
                    end
                end
                ST_ACK_CTRL: begin
                    if (fall_ev) begin
                        st_next = rw_reg ? ST_TX : ST_WADDR;
                        drv_low_next = rw_reg & ~rd_data[7];
                    end
                end
                ST_ACK_ADDR, ST_ACK_DATA: begin
                    if (fall_ev) begin
                        st_next = ST_WDATA;
                        drv_low_next = 1'b0;
                    end
                end
                ST_TX: begin
                    if (fall_ev && bitcnt_reg == TX_LAST) begin
                        st_next = ST_RACK;
                        drv_low_next = 1'b0;
                    end else if (fall_ev) begin
                        drv_low_next = ~tx_reg[6];
                    end
                end
                ST_RACK: begin
                    if (bit_ev && sda_lvl) begin
                        st_next = ST_IDLE;
                        drv_low_next = 1'b0;
                    end else if (fall_ev) begin
                        st_next = ST_TX;
                        drv_low_next = ~rd_data[7];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            st_reg <= ST_IDLE;
            drv_low_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            drv_low_reg <= drv_low_next;
        end
    end

    // ==========================================
    // Shifters and bit counter
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            bitcnt_reg <= 4'h0;
            sh_reg <= 8'h00;
            tx_reg <= 8'h00;
            rw_reg <= 1'b0;
        end else if (start_ev || stop_ev || byte_done || load_tx) begin
            bitcnt_reg <= 4'h0;
            if (byte_done && st_reg == ST_CTRL) begin
                rw_reg <= sh_reg[0];
            end
            if (load_tx) begin
                tx_reg <= rd_data;
            end
        end else if (bit_ev && rx_state && bitcnt_reg != BIT_LAST) begin
            sh_reg <= {sh_reg[6:0], sda_lvl};
            bitcnt_reg <= bitcnt_reg + 4'h1;
        end else if (fall_ev && st_reg == ST_TX) begin
            tx_reg <= {tx_reg[6:0], 1'b0};
            bitcnt_reg <= bitcnt_reg + 4'h1;
        end
    end

    // ==========================================
    // Address pointer and page buffer
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            ptr_reg <= PTR_RESET;
            wr_base_reg <= 4'h0;
            buf_vld_reg <= '0;
            wr_pend_reg <= 1'b0;
        end else if (start_ev || stop_ev) begin
            wr_pend_reg <= 1'b0;
        end else if (byte_done && st_reg == ST_WADDR) begin
            ptr_reg <= sh_reg;
            wr_base_reg <= sh_reg[7:4];
            buf_vld_reg <= '0;
        end else if (byte_done && st_reg == ST_WDATA) begin
            ptr_reg <= page_inc;
            buf_vld_reg[ptr_reg[3:0]] <= 1'b1;
            wr_pend_reg <= 1'b1;
        end else if (load_tx) begin
            ptr_reg <= ptr_inc;
        end
    end

    always_ff @(posedge core_clk) begin
        if (byte_done && st_reg == ST_WDATA) begin
            page_buf[ptr_reg[3:0]] <= sh_reg;
        end
        if (commit_we) begin
            mem[commit_addr] <= page_buf[commit_idx];
        end
    end

    // ==========================================
    // Self-timed write cycle
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            busy_reg <= 1'b0;
            busy_cnt_reg <= '0;
        end else if (stop_ev && wr_pend_reg) begin
            busy_reg <= 1'b1;
            busy_cnt_reg <= CNT_W'(WRITE_CYC);
        end else if (busy_reg) begin
            busy_cnt_reg <= busy_cnt_reg - CNT_W'(1);
            busy_reg <= busy_cnt_reg != CNT_W'(1);
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe = drv_low_reg;
    assign write_busy = busy_reg;

    // ==========================================
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    busy_no_ack_a: assert property (
        (byte_done && st_reg == ST_CTRL && busy_reg) |=> !sda_oe [*2])
        else $error("control byte acknowledged while busy");
    ctrl_ack_a: assert property (
        (byte_done && st_reg == ST_CTRL && !busy_reg && ctrl_match) |=> sda_oe && st_reg == ST_ACK_CTRL)
        else $error("matching control byte not acknowledged");
    wp_guard_a: assert property (
        commit_we |-> !(wp_on && commit_addr >= 8'h80))
        else $error("protected location written");
    wp_low_a: assert property (
        (commit_on && buf_vld_reg[commit_idx] && (!wp_on || commit_addr < 8'h80)) |-> commit_we)
        else $error("unprotected byte not stored");
    busy_start_a: assert property (
        (stop_ev && wr_pend_reg) |=> busy_reg && busy_cnt_reg == CNT_W'(WRITE_CYC))
        else $error("write cycle not started on stop");
    busy_hold_a: assert property (
        $rose(busy_reg) |-> busy_reg [*8])
        else $error("write cycle ended early");
    ptr_step_a: assert property (
        load_tx |=> ptr_reg == 8'($past(ptr_reg) + PTR_STEP) && tx_reg == $past(rd_data))
        else $error("pointer or read byte wrong");
    ptr_wrap_a: assert property (
        (load_tx && ptr_reg == 8'hff) |=> ptr_reg == 8'h00)
        else $error("pointer did not wrap");
    page_wrap_a: assert property (
        (byte_done && st_reg == ST_WDATA) |=> ptr_reg[7:4] == $past(ptr_reg[7:4]))
        else $error("page write left its page");
    nack_free_a: assert property (
        (st_reg == ST_RACK && bit_ev && sda_lvl && !start_ev && !stop_ev) |=> !sda_oe && st_reg == ST_IDLE)
        else $error("data line held after nack");
    read_sel_a: assert property (
        (st_reg == ST_ACK_CTRL && fall_ev && !start_ev && !stop_ev) |=> st_reg == ($past(rw_reg) ? ST_TX : ST_WADDR))
        else $error("direction bit ignored");
endmodule : sep_eeprom_top

// [verif/sep_bus_master.sv]
`timescale 1ns/1ns
module sep_bus_master (
    // Timing reference
    input wire logic core_clk,
    // Bus wires
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low
);
    // ==========================================
    // Bus phase lengths in core cycles
    // Low phase 2.6 us: data moves 1.6 us after fall, clear of the device turn-around
    localparam int T_CHG = 160;
    localparam int T_SET = 100;
    localparam int T_HIGH = 200;

    initial begin
        scl_o = 1'b1;
        sda_low = 1'b0;
    end

    task automatic wt(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : wt

    // ==========================================
    // Conditions and bits
    task automatic bus_start();
        wt(T_CHG);
        sda_low = 1'b0;
        wt(T_SET);
        scl_o = 1'b1;
        wt(T_HIGH);
        sda_low = 1'b1;
        wt(T_HIGH);
        scl_o = 1'b0;
    endtask : bus_start

    task automatic bus_stop();
        wt(T_CHG);
        sda_low = 1'b1;
        wt(T_SET);
        scl_o = 1'b1;
        wt(T_HIGH);
        sda_low = 1'b0;
        wt(T_HIGH);
    endtask : bus_stop

    task automatic bus_bit(input logic b, output logic r);
        wt(T_CHG);
        sda_low = ~b;
        wt(T_SET);
        scl_o = 1'b1;
        wt(T_HIGH);
        r = sda_i;
        scl_o = 1'b0;
    endtask : bus_bit

    // ==========================================
    // Bytes, MSB first
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bus_bit(d[i], r);
        end
        bus_bit(1'b1, r);
        ack = ~r;
    endtask : send_byte

    task automatic recv_byte(input logic ack, output logic [7:0] d, output logic lvl);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bus_bit(1'b1, r);
            d[i] = r;
        end
        bus_bit(~ack, lvl);
    endtask : recv_byte
endmodule : sep_bus_master

// [verif/sep_eeprom_tb_top.sv]
`timescale 1ns/1ns
module sep_eeprom_tb_top;
    import sep_pkg::*;
    localparam int WCYC = 5000;
    logic core_clk, link_clk, rstn, scl, sda_low, sda_o, sda_oe, wp, write_busy, sda_wire;
    logic [2:0] cs;
    logic [31:0] lfsr_state;
    logic [7:0] v0, v1, v2, ctrl_w, ctrl_r, ctrl_x;
    int failures, samples_checked, cyc;

    // Open-drain wire with pull-up
    assign sda_wire = (sda_oe ? sda_o : 1'b1) & ~sda_low;
    assign ctrl_w = {CTRL_CODE, cs, 1'b0};
    assign ctrl_r = {CTRL_CODE, cs, 1'b1};

    sep_eeprom_top #(.WRITE_CYC(WCYC)) u_sep_eeprom_top (
        .core_clk(core_clk), .rstn(rstn), .link_clk(link_clk), .scl_i(scl), .sda_i(sda_wire),
        .sda_o(sda_o), .sda_oe(sda_oe), .wp_i(wp), .chip_select_bit_2(cs[2]),
        .chip_select_bit_1(cs[1]), .chip_select_bit_0(cs[0]), .write_busy(write_busy)
    );
    sep_bus_master u_sep_bus_master (.core_clk(core_clk), .sda_i(sda_wire), .scl_o(scl), .sda_low(sda_low));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        link_clk = 1'b0;
        #17;
        forever #40 link_clk = ~link_clk;
    end

    // ==========================================
    // Helpers
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        lfsr_next = s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
    endfunction : lfsr_next

    function automatic logic sel_ok(input logic [7:0] c);
        sel_ok = c[7:4] == CTRL_CODE && c[3:1] == cs;
    endfunction : sel_ok

    task automatic draw(output logic [7:0] v);
        lfsr_state = lfsr_next(lfsr_state);
        v = lfsr_state[7:0];
    endtask : draw

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            failures++;
        end
    endtask : chk

    task automatic put(input logic [7:0] d, input logic exp);
        logic a;
        u_sep_bus_master.send_byte(d, a);
        chk({7'h00, a}, {7'h00, exp});
    endtask : put

    task automatic get(input logic [7:0] exp, input logic ack);
        logic [7:0] d;
        logic lvl;
        u_sep_bus_master.recv_byte(ack, d, lvl);
        chk(d, exp);
        if (!ack) begin
            chk({7'h00, lvl}, 8'h01);
        end
    endtask : get

    task automatic wait_idle();
        int n;
        n = 0;
        while (write_busy !== 1'b0 && n < WCYC + 200) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chk({7'h00, write_busy}, 8'h00);
    endtask : wait_idle

    task automatic give_verdict();
        if (failures == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : give_verdict

    // ==========================================
    // Hang guard
    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (cyc == 115000) begin
            failures++;
            give_verdict();
        end
    end

    // ==========================================
    // Main sequence
    initial begin
        rstn = 1'b0;
        wp = 1'b0;
        failures = 0;
        samples_checked = 0;
        cyc = 0;
        lfsr_state = 32'hf0e45de6;
        draw(v0);
        cs = v0[2:0];
        draw(v0);
        draw(v1);
        draw(v2);
        ctrl_x = {CTRL_CODE, cs ^ (v2[2:0] | 3'b001), 1'b0};
        // Reset, then settle time for the link domain
        repeat (12) @(posedge core_clk);
        #1;
        rstn = 1'b1;
        repeat (100) @(posedge core_clk);
        #1;
        // Unprotected write to top location, then acknowledge polling
        u_sep_bus_master.bus_start();
        put(ctrl_w, sel_ok(ctrl_w));
        put(8'hff, 1'b1);
        put(v0, 1'b1);
        u_sep_bus_master.bus_stop();
        u_sep_bus_master.bus_start();
        put(ctrl_w, 1'b0);
        u_sep_bus_master.bus_start();
        put(ctrl_w, 1'b1);
        // Lower half still writable with protection on, straight after the poll
        wp = 1'b1;
        put(8'h00, 1'b1);
        put(v1, 1'b1);
        put(v2, 1'b1);
        u_sep_bus_master.bus_stop();
        wait_idle();
        // Protected write: acked, busy, not stored
        u_sep_bus_master.bus_start();
        put(ctrl_w, 1'b1);
        put(8'hff, 1'b1);
        put(~v0, 1'b1);
        u_sep_bus_master.bus_stop();
        repeat (100) @(posedge core_clk);
        #1;
        chk({7'h00, write_busy}, 8'h01);
        wait_idle();
        // Random read at top, sequential across the wrap
        u_sep_bus_master.bus_start();
        put(ctrl_w, 1'b1);
        put(8'hff, 1'b1);
        u_sep_bus_master.bus_start();
        put(ctrl_r, 1'b1);
        get(v0, 1'b1);
        get(v1, 1'b0);
        u_sep_bus_master.bus_stop();
        // Current-address read follows the last byte
        u_sep_bus_master.bus_start();
        put(ctrl_r, 1'b1);
        get(v2, 1'b0);
        u_sep_bus_master.bus_stop();
        // Foreign chip select is ignored
        u_sep_bus_master.bus_start();
        put(ctrl_x, sel_ok(ctrl_x));
        u_sep_bus_master.bus_stop();
        give_verdict();
    end
endmodule : sep_eeprom_tb_top
